// ==== hdl/dfs_pkg.sv ====
/*
 Constants, register layout, reset values and types of the drive fault action supervisor.
 Assumes a 100 MHz control clock, and that percentages are carried as tenths of a percent, except the overload coefficient in whole percent.
*/
// Notes on behaviour
// - Second action word: comms, external, speed deviation, user fault one, user fault two.
// - Each action digit: 0 coast to stop, 1 stop by stop mode, 2 keep running.
// - First action word: tens reserved; input phase, output phase, parameter access above it.
// - Third action word: feedback loss, load loss, reserved, run time, cumulative run time.
// - Coast response shows the fault at once and cuts the output directly.
// - Stop-mode response shows alarm while stopping, then shows the fault once stopped.
// - Keep-running response shows alarm and runs at the fallback frequency.
// - Fallback selector 0 to 4, default 1: current, set, upper, lower, standby.
// - Standby frequency is a share of maximum frequency, default full, used on fault only.
// - Load loss: current below level times rated current longer than time, when enabled.
// - Speed deviation fault when speed error exceeds level longer than the deviation time.
// - Deviation and overspeed checks work only in vector mode without torque control.
// - Overspeed fault when speed exceeds maximum by the level for longer than the time.
// - An overspeed time of zero disables overspeed protection.
// - Overload coefficient 100 to 200 percent scales the overload current threshold.
// - Temperature pre-alarm and trip thresholds plus a sensor type selector.
// - The process control group acts only when main or auxiliary source equals 6.
// - Setpoint source selects one of seven; up/down only when main source equals 6.
// - The setpoint is a relative 0 to 100 percent, independent of the display range.
// - The controller works on the error between target and feedback.
// - The ones digit of the first word governs motor overload.
// - Feedback below loss level longer than loss time acts by third word ones digit.
package dfs_pkg;
   localparam int CLK_FREQ_HZ = 100_000_000;
   localparam int TICK_TIME_MS = 100;
   localparam int TICK_CYCLES_DEF = CLK_FREQ_HZ / 1000 * TICK_TIME_MS;
   localparam int NCFG = 24;
   localparam int NFLT = 16;
   localparam int NDET = 4;
   // Configuration register indices; the byte offset is four times the index.
   localparam int IX_ACT1 = 0;
   localparam int IX_ACT2 = 1;
   localparam int IX_ACT3 = 2;
   localparam int IX_FBSEL = 3;
   localparam int IX_STBY = 4;
   localparam int IX_LLEN = 5;
   localparam int IX_LLLVL = 6;
   localparam int IX_LLTIM = 7;
   localparam int IX_SDLVL = 8;
   localparam int IX_SDTIM = 9;
   localparam int IX_OSLVL = 10;
   localparam int IX_OSTIM = 11;
   localparam int IX_OLCOEF = 12;
   localparam int IX_TPRE = 13;
   localparam int IX_TTRIP = 14;
   localparam int IX_TTYPE = 15;
   localparam int IX_PSRC = 16;
   localparam int IX_PDIG = 17;
   localparam int IX_PRANGE = 18;
   localparam int IX_PFLLVL = 19;
   localparam int IX_PFLTIM = 20;
   localparam int IX_MAINSRC = 21;
   localparam int IX_AUXSRC = 22;
   localparam int IX_MAXF = 23;
   localparam logic [15:0] CFG_RST [NCFG] = '{
      16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h03E8, 16'h0000, 16'h00C8, 16'h0032,
      16'h00C8, 16'h0000, 16'h00C8, 16'h0014, 16'h0064, 16'h0050, 16'h0064, 16'h0000,
      16'h0000, 16'h01F4, 16'h03E8, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h1388};
   // Status register offsets.
   localparam logic [7:0] OFS_LATCH = 8'h60;
   localparam logic [7:0] OFS_CLEAR = 8'h64;
   localparam logic [7:0] OFS_STATE = 8'h68;
   localparam logic [7:0] OFS_RUNF = 8'h6C;
   // Action digit codes and fixed scales.
   localparam logic [1:0] ACT_COAST = 2'h0;
   localparam logic [1:0] ACT_RAMP = 2'h1;
   localparam logic [1:0] ACT_RUN = 2'h2;
   localparam logic [15:0] PERMILLE_FULL = 16'h03E8;
   localparam logic [15:0] PERCENT_FULL = 16'h0064;
   localparam logic [15:0] FREQ_SRC_PID = 16'h0006;
   localparam logic [15:0] PSRC_UPDOWN = 16'h0006;
   localparam logic [15:0] UD_STEP = 16'h0001;
   localparam logic [15:0] FAULT_RSV_MASK = 16'h1002;
   localparam int FI_SPEED_DEV = 7;
   localparam int FI_PID_LOSS = 10;
   localparam int FI_LOAD_LOSS = 11;
   localparam int FI_OVERSPEED = 15;
   localparam int DET_LOAD = 0;
   localparam int DET_SDEV = 1;
   localparam int DET_OVSP = 2;
   localparam int DET_PIDL = 3;
   typedef enum logic [4:0] {
      ST_OK = 5'h01,
      ST_RUNON = 5'h02,
      ST_RAMP = 5'h04,
      ST_TRIP = 5'h08,
      ST_COAST = 5'h10
   } dfs_state_t;
endpackage

// ==== hdl/dfs_supervisor.sv ====
/*
 Drive fault action supervisor: fault latch and response state machine, the four
 threshold-and-duration detectors, fallback frequency, overload and temperature
 thresholds, and the process control setpoint front end, behind a classic Wishbone slave.
 Assumes measurements arrive on clk from the power stage logic, while fault and up/down
 terminals are asynchronous pins.
*/
`timescale 1ns/1ps
module dfs_supervisor
   import dfs_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [NFLT-1:0] fault_pin,
   input wire logic up_pin,
   input wire logic down_pin,
   input wire logic drive_stopped,
   input wire logic vector_mode,
   input wire logic torque_mode,
   input wire logic [15:0] out_current,
   input wire logic [15:0] motor_rated_current,
   input wire logic [15:0] speed_actual,
   input wire logic [15:0] speed_set,
   input wire logic [15:0] cur_freq,
   input wire logic [15:0] set_freq,
   input wire logic [15:0] upper_freq,
   input wire logic [15:0] lower_freq,
   input wire logic [15:0] pid_feedback,
   input wire logic [15:0] analog_input_one,
   input wire logic [15:0] analog_input_two,
   input wire logic [15:0] comm_setpoint,
   input wire logic [15:0] pulse_setpoint,
   input wire logic [15:0] multiseg_setpoint,
   input wire logic [7:0] motor_temp,
   output logic fault_display,
   output logic alarm_display,
   output logic coast_cmd,
   output logic ramp_stop_cmd,
   output logic keep_running,
   output logic [15:0] run_freq,
   output logic [3:0] fault_source,
   output logic overload_limit_valid,
   output logic [15:0] overload_limit,
   output logic temp_prealarm,
   output logic temp_trip,
   output logic [1:0] temp_sensor_type,
   output logic pid_enable,
   output logic [15:0] pid_setpoint,
   output logic signed [16:0] pid_error
);
   logic [15:0] cfg [NCFG];
   logic [15:0] latch;
   logic [15:0] flt_meta, flt_sync;
   logic [2:0] up_sh, down_sh;
   logic [23:0] tick_cnt;
   logic tick;
   logic [15:0] det_cnt [NDET];
   logic [NDET-1:0] det_cond, det_en, det_trip;
   logic [15:0] det_lim [NDET];
   logic [1:0] act [NFLT];
   logic [NFLT-1:0] is_coast, is_ramp, is_run, raise;
   dfs_state_t state, next_state;
   logic [15:0] ud_value, fallback, stby_freq, sd_thr, os_thr, spd_diff, pid_sel, pid_sp_next;
   logic [31:0] ll_lhs, ll_rhs;
   logic [5:0] widx;
   logic bus_req, bus_wr;
   logic pid_group_on, vec_nt;

   // Bus decode; the word index ignores the two byte-address bits.
   // A write lands at the edge where the master samples ack, while it still holds the data.
   assign widx = wb_adr_i[7:2];
   assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

   // Single-wait-state acknowledge; ack drops the cycle after it was given.
   always_ff @(posedge clk) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= bus_req;
      end
   end

   // Read mux; unmapped words read as zero and are still acknowledged.
   always_ff @(posedge clk) begin
      if (rst) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (bus_req) begin
         if (widx < 6'(NCFG)) begin
            wb_dat_o <= {16'h0000, cfg[widx[4:0]]};
         end else begin
            case (wb_adr_i)
               OFS_LATCH: wb_dat_o <= {16'h0000, latch};
               OFS_STATE: wb_dat_o <= {23'h000000, fault_source, state};
               OFS_RUNF: wb_dat_o <= {16'h0000, run_freq};
               default: wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Configuration words with byte enables on the two low lanes.
   for (genvar g = 0; g < NCFG; g++) begin : g_cfg
      always_ff @(posedge clk) begin
         if (rst) begin
            cfg[g] <= CFG_RST[g];
         end else if (bus_wr && widx == 6'(g)) begin
            if (wb_sel_i[0]) begin
               cfg[g][7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
               cfg[g][15:8] <= wb_dat_i[15:8];
            end
         end
      end
   end

   // Two-stage synchronisers for the asynchronous fault and terminal pins.
   always_ff @(posedge clk) begin
      if (rst) begin
         flt_meta <= 16'h0000;
         flt_sync <= 16'h0000;
         up_sh <= 3'h0;
         down_sh <= 3'h0;
      end else begin
         flt_meta <= fault_pin;
         flt_sync <= flt_meta;
         up_sh <= {up_sh[1:0], up_pin};
         down_sh <= {down_sh[1:0], down_pin};
      end
   end

   // Tenth-of-a-second time base for the detectors; shortened in simulation by parameter.
   always_ff @(posedge clk) begin
      if (rst || tick) begin
         tick_cnt <= 24'h000000;
      end else begin
         tick_cnt <= tick_cnt + 24'h000001;
      end
   end
   assign tick = (tick_cnt == 24'(TICK_CYCLES - 1));

   assign vec_nt = vector_mode && !torque_mode;
   assign pid_group_on = (cfg[IX_MAINSRC] == FREQ_SRC_PID) || (cfg[IX_AUXSRC] == FREQ_SRC_PID);

   // Detector thresholds; percentages of maximum frequency are tenths of a percent.
   always_comb begin
      ll_lhs = 32'(out_current) * 32'(PERMILLE_FULL);
      ll_rhs = 32'(cfg[IX_LLLVL]) * 32'(motor_rated_current);
      sd_thr = 16'((32'(cfg[IX_SDLVL]) * 32'(cfg[IX_MAXF])) / 32'(PERMILLE_FULL));
      os_thr = 16'((32'(cfg[IX_OSLVL]) * 32'(cfg[IX_MAXF])) / 32'(PERMILLE_FULL));
      spd_diff = (speed_actual >= speed_set) ? (speed_actual - speed_set)
                                             : (speed_set - speed_actual);
      det_cond[DET_LOAD] = ll_lhs < ll_rhs;
      det_cond[DET_SDEV] = spd_diff > sd_thr;
      det_cond[DET_OVSP] = {1'b0, speed_actual} > ({1'b0, cfg[IX_MAXF]} + {1'b0, os_thr});
      det_cond[DET_PIDL] = pid_feedback < cfg[IX_PFLLVL];
      det_en[DET_LOAD] = cfg[IX_LLEN][0];
      det_en[DET_SDEV] = vec_nt;
      det_en[DET_OVSP] = vec_nt && (cfg[IX_OSTIM] != 16'h0000);
      det_en[DET_PIDL] = pid_group_on && !drive_stopped;
      det_lim[DET_LOAD] = cfg[IX_LLTIM];
      det_lim[DET_SDEV] = cfg[IX_SDTIM];
      det_lim[DET_OVSP] = cfg[IX_OSTIM];
      det_lim[DET_PIDL] = cfg[IX_PFLTIM];
   end

   // Elapsed-time counters; a trip needs the count to pass the programmed time.
   for (genvar k = 0; k < NDET; k++) begin : g_det
      always_ff @(posedge clk) begin
         if (rst || !det_cond[k] || !det_en[k]) begin
            det_cnt[k] <= 16'h0000;
         end else if (tick && det_cnt[k] != 16'hFFFF) begin
            det_cnt[k] <= det_cnt[k] + 16'h0001;
         end
      end
      assign det_trip[k] = det_en[k] && det_cond[k] && (det_cnt[k] > det_lim[k]);
   end

   // Action digit per source; overspeed has no digit and always coasts.
   for (genvar i = 0; i < NFLT; i++) begin : g_act
      if (i == FI_OVERSPEED) begin : g_fixed
         assign act[i] = ACT_COAST;
      end else begin : g_digit
         assign act[i] = cfg[i / 5][2 * (i % 5) + 1 : 2 * (i % 5)];
      end
      assign is_coast[i] = latch[i] && (act[i] != ACT_RAMP) && (act[i] != ACT_RUN);
      assign is_ramp[i] = latch[i] && (act[i] == ACT_RAMP);
      assign is_run[i] = latch[i] && (act[i] == ACT_RUN);
   end

   // Fault sources: pins plus the internal detectors; reserved digits never latch.
   always_comb begin
      raise = flt_sync & ~FAULT_RSV_MASK;
      raise[FI_SPEED_DEV] = flt_sync[FI_SPEED_DEV] || det_trip[DET_SDEV];
      raise[FI_LOAD_LOSS] = flt_sync[FI_LOAD_LOSS] || det_trip[DET_LOAD];
      raise[FI_PID_LOSS] = flt_sync[FI_PID_LOSS] || det_trip[DET_PIDL];
      raise[FI_OVERSPEED] = flt_sync[FI_OVERSPEED] || det_trip[DET_OVSP];
   end

   // Sticky fault latch; a raise in the same cycle as a clear keeps the bit set.
   always_ff @(posedge clk) begin
      if (rst) begin
         latch <= 16'h0000;
      end else if (bus_wr && wb_adr_i == OFS_CLEAR) begin
         latch <= (latch & ~wb_dat_i[15:0]) | raise;
      end else begin
         latch <= latch | raise;
      end
   end

   // Response selection: coasting outranks a ramp stop, which outranks running on.
   always_comb begin
      next_state = state;
      case (state)
         ST_OK, ST_RUNON: begin
            if (|is_coast) begin
               next_state = ST_COAST;
            end else if (|is_ramp) begin
               next_state = ST_RAMP;
            end else if (|is_run) begin
               next_state = ST_RUNON;
            end else begin
               next_state = ST_OK;
            end
         end
         ST_RAMP: begin
            if (|is_coast) begin
               next_state = ST_COAST;
            end else if (latch == 16'h0000) begin
               next_state = ST_OK;
            end else if (drive_stopped) begin
               next_state = ST_TRIP;
            end
         end
         ST_TRIP, ST_COAST: begin
            if (latch == 16'h0000) begin
               next_state = ST_OK;
            end else if (|is_coast) begin
               next_state = ST_COAST;
            end
         end
         default: next_state = ST_OK;
      endcase
   end

   // State and indications come from the same next value, so they never disagree.
   always_ff @(posedge clk) begin
      if (rst) begin
         state <= ST_OK;
         fault_display <= 1'b0;
         alarm_display <= 1'b0;
         coast_cmd <= 1'b0;
         ramp_stop_cmd <= 1'b0;
         keep_running <= 1'b0;
      end else begin
         state <= next_state;
         fault_display <= (next_state == ST_COAST) || (next_state == ST_TRIP);
         coast_cmd <= next_state == ST_COAST;
         ramp_stop_cmd <= (next_state == ST_RAMP) || (next_state == ST_TRIP);
         alarm_display <= (next_state == ST_RAMP) || (next_state == ST_RUNON);
         keep_running <= next_state == ST_RUNON;
      end
   end

   // Lowest latched source is reported; the encoder scans every entry each cycle.
   always_ff @(posedge clk) begin
      if (rst) begin
         fault_source <= 4'h0;
      end else begin
         fault_source <= 4'h0;
         for (int j = NFLT - 1; j >= 0; j--) begin
            if (latch[j]) begin
               fault_source <= 4'(j);
            end
         end
      end
   end

   assign stby_freq = 16'((32'(cfg[IX_STBY]) * 32'(cfg[IX_MAXF])) / 32'(PERMILLE_FULL));

   always_comb begin
      case (cfg[IX_FBSEL])
         16'h0000: fallback = cur_freq;
         16'h0001: fallback = set_freq;
         16'h0002: fallback = upper_freq;
         16'h0003: fallback = lower_freq;
         16'h0004: fallback = stby_freq;
         default: fallback = set_freq;
      endcase
   end

   // Outside a run-on fault the command follows the set frequency.
   always_ff @(posedge clk) begin
      if (rst) begin
         run_freq <= 16'h0000;
      end else if (next_state == ST_RUNON) begin
         run_freq <= fallback;
      end else begin
         run_freq <= set_freq;
      end
   end

   // Motor protection thresholds; the limit is invalid for a coefficient out of range.
   always_ff @(posedge clk) begin
      if (rst) begin
         overload_limit <= 16'h0000;
         overload_limit_valid <= 1'b0;
         temp_prealarm <= 1'b0;
         temp_trip <= 1'b0;
         temp_sensor_type <= 2'h0;
      end else begin
         overload_limit <= 16'((32'(motor_rated_current) * 32'(cfg[IX_OLCOEF]))
                                / 32'(PERCENT_FULL));
         overload_limit_valid <= (cfg[IX_OLCOEF] >= PERCENT_FULL)
                                 && (cfg[IX_OLCOEF] <= 16'h00C8);
         temp_prealarm <= {8'h00, motor_temp} >= cfg[IX_TPRE];
         temp_trip <= {8'h00, motor_temp} >= cfg[IX_TTRIP];
         temp_sensor_type <= cfg[IX_TTYPE][1:0];
      end
   end

   // Up/down working copy of the digital setpoint, reloaded when software rewrites it.
   always_ff @(posedge clk) begin
      if (rst) begin
         ud_value <= CFG_RST[IX_PDIG];
      end else if (bus_wr && widx == 6'(IX_PDIG)) begin
         // The register takes its new value at this same edge, so the copy reads the bus.
         ud_value <= {wb_sel_i[1] ? wb_dat_i[15:8] : cfg[IX_PDIG][15:8],
                      wb_sel_i[0] ? wb_dat_i[7:0] : cfg[IX_PDIG][7:0]};
      end else if (cfg[IX_PSRC] == PSRC_UPDOWN && cfg[IX_MAINSRC] == FREQ_SRC_PID) begin
         if (up_sh[1] && !up_sh[2] && ud_value < PERMILLE_FULL) begin
            ud_value <= ud_value + UD_STEP;
         end else if (down_sh[1] && !down_sh[2] && ud_value != 16'h0000) begin
            ud_value <= ud_value - UD_STEP;
         end
      end else begin
         ud_value <= cfg[IX_PDIG];
      end
   end

   always_comb begin
      case (cfg[IX_PSRC])
         16'h0001: pid_sel = analog_input_one;
         16'h0002: pid_sel = analog_input_two;
         16'h0003: pid_sel = comm_setpoint;
         16'h0004: pid_sel = pulse_setpoint;
         16'h0005: pid_sel = multiseg_setpoint;
         16'h0006: pid_sel = (cfg[IX_MAINSRC] == FREQ_SRC_PID) ? ud_value : cfg[IX_PDIG];
         default: pid_sel = cfg[IX_PDIG];
      endcase
      pid_sp_next = (pid_sel > PERMILLE_FULL) ? PERMILLE_FULL : pid_sel;
   end

   // The display range register never enters this path.
   always_ff @(posedge clk) begin
      if (rst) begin
         pid_enable <= 1'b0;
         pid_setpoint <= 16'h0000;
         pid_error <= 17'sh00000;
      end else begin
         pid_enable <= pid_group_on;
         pid_setpoint <= pid_group_on ? pid_sp_next : 16'h0000;
         pid_error <= pid_group_on ? ($signed({1'b0, pid_sp_next}) - $signed({1'b0, pid_feedback}))
                                   : 17'sh00000;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
   coast_cuts_output_a: assert property (
      (|is_coast) |=> (fault_display && coast_cmd && !alarm_display))
      else $error("coast state without fault and coast");
   ramp_then_fault_a: assert property (
      (state == ST_RAMP && drive_stopped && !(|is_coast) && latch != 16'h0000)
      |=> (state == ST_TRIP) ##0 (fault_display && !alarm_display))
      else $error("stop-mode response did not show fault after stop");
   runon_freq_a: assert property (
      (next_state == ST_RUNON && cfg[IX_FBSEL] == 16'h0003)
      |=> (keep_running && alarm_display && run_freq == $past(lower_freq)))
      else $error("run-on not at lower limit frequency");
   no_vector_a: assert property (
      !vec_nt |=> (det_cnt[DET_SDEV] == 16'h0000 && det_cnt[DET_OVSP] == 16'h0000))
      else $error("speed checks counting outside vector mode");
   ovsp_zero_a: assert property (
      (cfg[IX_OSTIM] == 16'h0000) |-> !det_trip[DET_OVSP])
      else $error("overspeed trip with zero time");
   load_off_a: assert property (
      !cfg[IX_LLEN][0] |=> (det_cnt[DET_LOAD] == 16'h0000))
      else $error("load loss counting while disabled");
   pid_gate_a: assert property (
      !pid_group_on |=> (!pid_enable && pid_setpoint == 16'h0000))
      else $error("process control active without source 6");
   restart_count_a: assert property (
      (!det_cond[DET_PIDL]) |=> (det_cnt[DET_PIDL] == 16'h0000))
      else $error("feedback loss count not restarted");
   latch_set_wins_a: assert property (
      raise[0] |=> latch[0]) else $error("raised fault lost");
   setpoint_range_a: assert property (
      pid_setpoint <= PERMILLE_FULL) else $error("setpoint above full scale");

   coast_seen_c: cover property (state == ST_OK ##1 state == ST_COAST);
   ramp_trip_c: cover property (state == ST_RAMP ##1 state == ST_TRIP);
   runon_seen_c: cover property (state == ST_OK ##1 state == ST_RUNON ##[1:50] state == ST_OK);
endmodule

// ==== bench/dfs_stage_model.sv ====
/*
 Power stage stand-in that reports when the motor output has stopped.
 Assumes the stop commands are levels on the supervisor clock.
*/
`timescale 1ns/1ps
module dfs_stage_model #(
   parameter int STOP_CYC = 6
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic coast_cmd,
   input wire logic ramp_stop_cmd,
   input wire logic run_req,
   output logic drive_stopped
);
   int ramp_cnt;
   // A coast cuts the output at once; a ramped stop needs time, so the alarm phase is seen.
   always_ff @(posedge clk) begin
      if (rst || run_req) begin
         ramp_cnt <= 0;
         drive_stopped <= 1'b0;
      end else if (coast_cmd || ramp_cnt >= STOP_CYC) begin
         drive_stopped <= 1'b1;
      end else if (ramp_stop_cmd) begin
         ramp_cnt <= ramp_cnt + 1;
      end
   end
endmodule

// ==== bench/dfs_supervisor_tb.sv ====
/*
 Bench for the fault action supervisor: reset values, three responses, fallback, load loss,
 speed detectors, process control setpoint and motor protection thresholds.
 Assumes the stage model beside it and a ten-cycle detector tick.
*/
`timescale 1ns/1ps
module dfs_supervisor_tb
   import dfs_pkg::*;
;
   logic clk = 1'b0, rst = 1'b1, req = 1'b0, wb_we_i = 1'b0, run_req = 1'b0;
   logic up_pin = 1'b0, down_pin = 1'b0, vector_mode = 1'b1, torque_mode = 1'b0;
   logic [7:0] wb_adr_i = 8'h00, motor_temp = 8'h19;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0, rd;
   logic [NFLT-1:0] fault_pin = '0;
   logic [15:0] out_current = 16'h0300, motor_rated_current = 16'h03E8;
   logic [15:0] speed_actual = 16'h0100, speed_set = 16'h0100, cur_freq = 16'h0100;
   logic [15:0] set_freq = 16'h0200, upper_freq = 16'h0300, lower_freq = 16'h0040;
   logic [15:0] pid_feedback = 16'h0100, analog_input_one = 16'h0011;
   logic [15:0] analog_input_two = 16'h0022, comm_setpoint = 16'h0033;
   logic [15:0] pulse_setpoint = 16'h0044, multiseg_setpoint = 16'h0055;
   logic wb_cyc_i, wb_stb_i, wb_ack_o, drive_stopped, fault_display, alarm_display;
   logic coast_cmd, ramp_stop_cmd, keep_running, overload_limit_valid;
   logic temp_prealarm, temp_trip, pid_enable;
   logic [31:0] wb_dat_o;
   logic [3:0] fault_source;
   logic [1:0] temp_sensor_type;
   logic [15:0] run_freq, overload_limit, pid_setpoint;
   logic signed [16:0] pid_error;
   logic [15:0] fb_exp [5] = '{16'h0100, 16'h0200, 16'h0300, 16'h0040, 16'h09C4};
   int n_errors = 0, n_compared = 0;
   assign wb_cyc_i = req;
   assign wb_stb_i = req;
   // Free-running 100 MHz clock.
   always #5 clk = ~clk;
   dfs_supervisor #(.TICK_CYCLES(10)) dfs_supervisor_i (.*);
   dfs_stage_model dfs_stage_model_i (.clk(clk), .rst(rst), .coast_cmd(coast_cmd),
      .ramp_stop_cmd(ramp_stop_cmd), .run_req(run_req), .drive_stopped(drive_stopped));
   // Packs the indications as {source, fault, alarm, coast, ramp, keep running}.
   function automatic logic [31:0] ind();
      return {23'h0, fault_source, fault_display, alarm_display, coast_cmd, ramp_stop_cmd,
         keep_running};
   endfunction
   // Packs the protection outputs as {limit, valid, pre-alarm, trip, sensor type}.
   function automatic logic [31:0] prot();
      return {overload_limit, 11'h0, overload_limit_valid, temp_prealarm, temp_trip,
         temp_sensor_type};
   endfunction
   task automatic close_out();
      $display("Checks %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One classic cycle; the request holds until ack is sampled, so no wait is assumed.
   task automatic wb(input logic we, input logic [7:0] a, input logic [15:0] d);
      int n;
      n = 0;
      @(posedge clk);
      req <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= {16'h0, d};
      do begin
         @(posedge clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      rd = wb_dat_o;
      req <= 1'b0;
      if (wb_ack_o !== 1'b1) begin
         n_errors++;
         close_out();
      end
   endtask
   // Pins drop first, since a set beats a clear; then the drive is restarted.
   task automatic settle();
      @(posedge clk);
      fault_pin <= '0;
      repeat (4) @(posedge clk);
      wb(1'b1, OFS_CLEAR, 16'hFFFF);
      run_req <= 1'b1;
      @(posedge clk);
      run_req <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < NCFG; i++) begin
         wb(1'b0, 8'(i * 4), 16'h0);
         chk("cfg reset", rd, {16'h0, CFG_RST[i]});
      end
      wb(1'b0, 8'h70, 16'h0);
      chk("unmapped", rd, 32'h0);
      chk("protect reset", prot(), 32'h03E8_0010);
      $display("Test reset done");
      fault_pin[5] <= 1'b1;
      repeat (6) @(posedge clk);
      chk("coast", ind(), 32'hB4);
      settle();
      $display("Test coast done");
      wb(1'b1, 8'(IX_ACT2 * 4), 16'h0004);
      fault_pin[6] <= 1'b1;
      repeat (6) @(posedge clk);
      chk("ramp", ind(), 32'hCA);
      repeat (20) @(posedge clk);
      chk("stopped", 32'({fault_display, alarm_display}), 32'h2);
      settle();
      $display("Test ramp done");
      wb(1'b1, 8'(IX_ACT2 * 4), 16'h0080);
      wb(1'b1, 8'(IX_STBY * 4), 16'h01F4);
      fault_pin[8] <= 1'b1;
      repeat (6) @(posedge clk);
      for (int s = 0; s < 5; s++) begin
         wb(1'b1, 8'(IX_FBSEL * 4), 16'(s));
         repeat (3) @(posedge clk);
         chk("fallback", 32'(run_freq), 32'(fb_exp[s]));
      end
      chk("run on", ind(), 32'h109);
      settle();
      $display("Test run on done");
      wb(1'b1, 8'(IX_LLEN * 4), 16'h0001);
      wb(1'b1, 8'(IX_LLTIM * 4), 16'h0002);
      repeat (2) begin
         out_current <= 16'h0064;
         repeat (18) @(posedge clk);
         out_current <= 16'h0300;
         repeat (12) @(posedge clk);
      end
      chk("load early", 32'(fault_display), 32'h0);
      out_current <= 16'h0064;
      repeat (60) @(posedge clk);
      chk("load trip", ind(), 32'h174);
      $display("Test load loss done");
      speed_actual <= 16'h1800;
      vector_mode <= 1'b0;
      wb(1'b1, 8'(IX_OSTIM * 4), 16'h0000);
      repeat (40) @(posedge clk);
      wb(1'b0, OFS_LATCH, 16'h0);
      chk("vector off", rd, 32'h0800);
      vector_mode <= 1'b1;
      repeat (250) @(posedge clk);
      wb(1'b0, OFS_LATCH, 16'h0);
      chk("deviation", rd, 32'h0880);
      wb(1'b1, 8'(IX_OSTIM * 4), 16'h0001);
      repeat (40) @(posedge clk);
      wb(1'b0, OFS_LATCH, 16'h0);
      chk("overspeed", rd, 32'h8880);
      $display("Test speed done");
      wb(1'b1, 8'(IX_MAINSRC * 4), 16'h0006);
      repeat (2) @(posedge clk);
      chk("pid on", 32'(pid_enable), 32'h1);
      chk("pid digital", {pid_error[15:0], pid_setpoint}, 32'h00F4_01F4);
      analog_input_one <= 16'h0500;
      wb(1'b1, 8'(IX_PSRC * 4), 16'h0001);
      repeat (2) @(posedge clk);
      chk("pid clamp", 32'(pid_setpoint), 32'h03E8);
      wb(1'b1, 8'(IX_PSRC * 4), 16'h0006);
      up_pin <= 1'b1;
      repeat (5) @(posedge clk);
      up_pin <= 1'b0;
      repeat (2) @(posedge clk);
      chk("pid up", 32'(pid_setpoint), 32'h01F5);
      $display("Test process control done");
      motor_temp <= 8'h5A;
      wb(1'b1, 8'(IX_OLCOEF * 4), 16'h00C8);
      repeat (2) @(posedge clk);
      chk("protect", prot(), 32'h07D0_0018);
      motor_temp <= 8'h64;
      wb(1'b1, 8'(IX_OLCOEF * 4), 16'h00C9);
      wb(1'b1, 8'(IX_TTYPE * 4), 16'h0002);
      repeat (2) @(posedge clk);
      chk("protect range", prot(), 32'h07DA_000E);
      $display("Test protection done");
      close_out();
   end
endmodule
